// file: inc/iatr_defines.vh
/*
 * Constants for the input alarm threshold register bank: register
 * offsets, field positions, reset values and alarm status bit positions.
 * Assumes inclusion by bare name from the design file.
 */
`ifndef IATR_DEFINES_VH
`define IATR_DEFINES_VH

// =====================================================================
// Register byte addresses
// =====================================================================
`define IATR_ALARM_STATUS_OFF 12'h020
`define IATR_UPPER_TH_OFF 12'h024
`define IATR_LOWER_TH_OFF 12'h028
`define IATR_RESULT_OFF 12'h02C

// =====================================================================
// Field positions and widths
// =====================================================================
`define IATR_HYST_MSB 31
`define IATR_HYST_LSB 26
`define IATR_HYST_PAD_MSB 25
`define IATR_HYST_PAD_LSB 24
`define IATR_LIMIT_MSB 15
`define IATR_LIMIT_LSB 0
`define IATR_EXT_PAD 2'h0

// =====================================================================
// Reset values
// =====================================================================
`define IATR_HYST_RST 6'h00
`define IATR_UPPER_RST 16'hFFFF
`define IATR_LOWER_RST 16'h0000

// =====================================================================
// Alarm status bit positions
// =====================================================================
`define IATR_ST_SUMMARY 0
`define IATR_ST_TRP_OVER 4
`define IATR_ST_TRP_UNDER 5
`define IATR_ST_ACT_OVER 10
`define IATR_ST_ACT_UNDER 11

`endif

// file: hdl/iatr_regs.v
/*
 * Input alarm threshold register bank with APB slave, limit compare with
 * hysteresis release, and alarm status reporting.
 * Assumes a conversion result with a one-cycle valid strobe in the pclk
 * domain, and an APB master that follows the standard two-phase transfer.
 */
// Summary of operation
// RULE1: Hysteresis lives in bits 31..26 of upper register, read/write, resets zero.
// RULE2: Software writes zero into hysteresis bits 25 and 24.
// RULE3: Upper register bits 23..16 are read-only and read zero.
// RULE4: Upper limit in bits 15..0, resets FFFF, compared with two zero LSBs.
// RULE5: Lower limit in bits 15..0, resets zero, compared with two zero LSBs.
// RULE6: Lower register bits 31..16 are read-only and read zero.
// RULE7: Upper register bytes sit at ascending addresses, low byte first.
// RULE8: Lower register bytes sit at ascending addresses, low byte first.
// RULE9: Status bit 0 is the OR of all tripped alarm flags.
// RULE10: Separate active and tripped flags for input over and under alarms.
// RULE11: Each result is compared with both limits; hysteresis governs release.
`timescale 1ns/1ps
`include "iatr_defines.vh"

module iatr_regs #(
    parameter RES_W = 18,
    parameter ADDR_W = 12
) (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [ADDR_W-1:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // Conversion result
    input wire [RES_W-1:0] conv_result,
    input wire conv_valid,
    // Alarm state
    output reg alarm_over_r,
    output reg alarm_under_r,
    output reg summary_alarm_bit_r
);

// =====================================================================
// Register storage
// =====================================================================
reg [5:0] input_alarm_hysteresis_r;
reg [15:0] input_alarm_upper_limit_r;
reg [15:0] input_alarm_lower_limit_r;
reg [RES_W-1:0] last_result_r;

wire [31:0] upper_threshold_register;
wire [31:0] lower_threshold_register;
wire [31:0] status_word;
wire [31:0] result_word;

// Pad bits 25..24 and 23..16 are constant zero, never stored
assign upper_threshold_register = {input_alarm_hysteresis_r, 2'h0, 8'h00,
    input_alarm_upper_limit_r}; // see RULE1 see RULE3
assign lower_threshold_register = {16'h0000, input_alarm_lower_limit_r}; // see RULE6

// =====================================================================
// APB decode
// =====================================================================
wire acc = psel & penable & ~pready;
// Writes land on the edge where the master samples pready high
wire wr = psel & penable & pready & pwrite;
wire hit_up = (paddr == `IATR_UPPER_TH_OFF);
wire hit_lo = (paddr == `IATR_LOWER_TH_OFF);
wire hit_st = (paddr == `IATR_ALARM_STATUS_OFF);
wire hit_res = (paddr == `IATR_RESULT_OFF);
wire hit_any = hit_up | hit_lo | hit_st | hit_res;
wire ro_wr = pwrite & (hit_st | hit_res);

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        pready <= 1'b0;
        pslverr <= 1'b0;
        prdata <= 32'h00000000;
    end else begin
        // One wait state: pready rises in the second access cycle
        pready <= acc;
        pslverr <= acc & (~hit_any | ro_wr);
        if (acc && !pwrite) begin
            if (hit_up)
                prdata <= upper_threshold_register;
            else if (hit_lo)
                prdata <= lower_threshold_register;
            else if (hit_st)
                prdata <= status_word;
            else if (hit_res)
                prdata <= result_word;
            else
                prdata <= 32'h00000000;
        end else begin
            prdata <= 32'h00000000;
        end
    end
end

// Byte lane n maps to byte address offset+n, lowest byte at lowest address
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        input_alarm_hysteresis_r <= `IATR_HYST_RST; // see RULE1
        input_alarm_upper_limit_r <= `IATR_UPPER_RST; // see RULE4
        input_alarm_lower_limit_r <= `IATR_LOWER_RST; // see RULE5
    end else if (wr) begin
        if (hit_up) begin
            if (pstrb[0])
                input_alarm_upper_limit_r[7:0] <= pwdata[7:0]; // see RULE7
            if (pstrb[1])
                input_alarm_upper_limit_r[15:8] <= pwdata[15:8]; // see RULE7
            // Bits 25..24 are dropped; software is expected to write zero
            if (pstrb[3])
                input_alarm_hysteresis_r <= pwdata[`IATR_HYST_MSB:`IATR_HYST_LSB]; // see RULE2
        end
        if (hit_lo) begin
            if (pstrb[0])
                input_alarm_lower_limit_r[7:0] <= pwdata[7:0]; // see RULE8
            if (pstrb[1])
                input_alarm_lower_limit_r[15:8] <= pwdata[15:8]; // see RULE8
        end
    end
end

// =====================================================================
// Compare with hysteresis
// =====================================================================
wire [RES_W-1:0] upper_ext = {input_alarm_upper_limit_r, `IATR_EXT_PAD}; // see RULE4
wire [RES_W-1:0] lower_ext = {input_alarm_lower_limit_r, `IATR_EXT_PAD}; // see RULE5
wire [RES_W-1:0] hyst_ext = {{(RES_W-8){1'b0}}, input_alarm_hysteresis_r, 2'h0};
// Release points saturate so a wide band near full scale cannot wrap
wire [RES_W:0] lo_rel_sum = {1'b0, lower_ext} + {1'b0, hyst_ext};
wire [RES_W-1:0] over_rel = (upper_ext > hyst_ext) ? (upper_ext - hyst_ext) : {RES_W{1'b0}};
wire [RES_W-1:0] under_rel = lo_rel_sum[RES_W] ? {RES_W{1'b1}} : lo_rel_sum[RES_W-1:0];

reg act_over_r;
reg act_under_r;
reg trp_over_r;
reg trp_under_r;
reg act_over_nxt;
reg act_under_nxt;

always @* begin
    act_over_nxt = act_over_r;
    act_under_nxt = act_under_r;
    if (conv_valid) begin
        // Raise past a limit; release only once below upper limit minus band or above lower limit plus band
        if (conv_result > upper_ext)
            act_over_nxt = 1'b1; // see RULE11
        else if (conv_result < over_rel)
            act_over_nxt = 1'b0; // see RULE11
        if (conv_result < lower_ext)
            act_under_nxt = 1'b1; // see RULE11
        else if (conv_result > under_rel)
            act_under_nxt = 1'b0; // see RULE11
    end
end

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        act_over_r <= 1'b0;
        act_under_r <= 1'b0;
        trp_over_r <= 1'b0;
        trp_under_r <= 1'b0;
        last_result_r <= {RES_W{1'b0}};
        alarm_over_r <= 1'b0;
        alarm_under_r <= 1'b0;
        summary_alarm_bit_r <= 1'b0;
    end else begin
        act_over_r <= act_over_nxt;
        act_under_r <= act_under_nxt;
        if (conv_valid) begin
            last_result_r <= conv_result;
            // Tripped flags follow the raw compare of the latest result
            trp_over_r <= (conv_result > upper_ext); // see RULE10
            trp_under_r <= (conv_result < lower_ext); // see RULE10
            summary_alarm_bit_r <= (conv_result > upper_ext) |
                (conv_result < lower_ext); // see RULE9
        end
        alarm_over_r <= act_over_nxt;
        alarm_under_r <= act_under_nxt;
    end
end

// =====================================================================
// Status and result words
// =====================================================================
reg [31:0] status_mux;
always @* begin
    status_mux = 32'h00000000;
    status_mux[`IATR_ST_SUMMARY] = summary_alarm_bit_r; // see RULE9
    status_mux[`IATR_ST_TRP_OVER] = trp_over_r; // see RULE10
    status_mux[`IATR_ST_TRP_UNDER] = trp_under_r; // see RULE10
    status_mux[`IATR_ST_ACT_OVER] = act_over_r; // see RULE10
    status_mux[`IATR_ST_ACT_UNDER] = act_under_r; // see RULE10
end
assign status_word = status_mux;
assign result_word = {{(32-RES_W){1'b0}}, last_result_r};

endmodule // iatr_regs

// file: tb/iatr_regs_checker.sv
/* Assertion checker for the alarm threshold register bank.
   Assumes it is bound to iatr_regs and sees only that module's ports. */
`timescale 1ns/1ps
module iatr_regs_checker (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // APB
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    // Alarm side
    input wire conv_valid,
    input wire alarm_over_r,
    input wire alarm_under_r,
    input wire summary_alarm_bit_r
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire rd = pready && !pwrite;
    wire st = paddr == 12'h020;
    wire [2:0] alarms = {alarm_over_r, alarm_under_r, summary_alarm_bit_r};
    // =====================================================================
    // Assertions
    a_ready_wait: assert property (psel && penable && !pready |=> pready) else $error("late");
    a_ready_pulse: assert property (pready |=> !pready) else $error("pready held");
    a_err_with_ready: assert property (pslverr |-> pready) else $error("stray pslverr");
    a_rdata_idle: assert property (!rd |-> prdata == 32'h0) else $error("prdata not idle");
    a_err_unmapped: assert property (pready && !(paddr inside {12'h020, 12'h024, 12'h028,
        12'h02C}) |-> pslverr) else $error("unmapped accepted");
    a_upper_rsvd: assert property (rd && paddr == 12'h024 |-> prdata[25:16] == 10'h000)
        else $error("upper reserved set");
    a_lower_rsvd: assert property (rd && paddr == 12'h028 |-> prdata[31:16] == 16'h0000)
        else $error("lower reserved set");
    a_summary_or: assert property (rd && st |-> prdata[0] == (prdata[4] | prdata[5]))
        else $error("summary not OR");
    a_status_pins: assert property (rd && st |-> prdata[11:10] == {alarm_under_r, alarm_over_r})
        else $error("status mismatch");
    a_alarm_hold: assert property (!conv_valid |=> $stable(alarms)) else $error("alarm moved");
    // Main scenarios
    cover property (rd && st && prdata[0]);
    cover property (pready && pwrite && paddr == 12'h024);
    cover property ($rose(alarm_under_r));
    cover property (pslverr);
endmodule // iatr_regs_checker
bind iatr_regs iatr_regs_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .conv_valid(conv_valid), .alarm_over_r(alarm_over_r),
    .alarm_under_r(alarm_under_r), .summary_alarm_bit_r(summary_alarm_bit_r));

// file: tb/iatr_regs_tb.sv
/* Self-checking bench for iatr_regs: byte-lane register writes, reserved bits, errors, alarms.
   Assumes the design answers each APB access with a one-cycle pready. */
`timescale 1ns/1ps
module iatr_regs_tb;
    reg pclk = 1'b0;
    reg presetn = 1'b0;
    reg psel = 1'b0, penable = 1'b0, pwrite = 1'b0, conv_valid = 1'b0;
    reg [11:0] paddr = 12'h000;
    reg [31:0] pwdata = 32'h0, seed = 32'h00002EE3, d, got, e_up, e_lo;
    reg [3:0] pstrb = 4'h0, s;
    reg [17:0] conv_result = 18'h00000;
    reg [131:0] tbl = {18'h20001, 4'hA, 18'h1FFF8, 4'h2, 18'h1FFEF, 4'h0,
        18'h03FFF, 4'h5, 18'h04008, 4'h1, 18'h04011, 4'h0};
    reg [21:0] x;
    reg err;
    wire [31:0] prdata;
    wire pready, pslverr, alarm_over_r, alarm_under_r, summary_alarm_bit_r;
    integer fail_count = 0, samples_checked = 0, cycles = 0, i;
    always #2.5 pclk = ~pclk;
    iatr_regs u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .conv_result(conv_result), .conv_valid(conv_valid),
        .alarm_over_r(alarm_over_r), .alarm_under_r(alarm_under_r),
        .summary_alarm_bit_r(summary_alarm_bit_r));
    // =====================================================================
    // Helpers
    function automatic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        rnd = seed;
    endfunction
    // Writable bits of a register restricted to the strobed lanes
    function [31:0] merge(input [31:0] old, input [31:0] wd, input [3:0] sb, input [31:0] rw);
        merge = {{8{sb[3]}}, {8{sb[2]}}, {8{sb[1]}}, {8{sb[0]}}} & rw;
        merge = (old & ~merge) | (wd & merge);
    endfunction
    function [31:0] stat(input [3:0] f);
        stat = {20'h00000, f[0], f[1], 4'h0, f[2], f[3], 3'h0, f[3] | f[2]};
    endfunction
    task chk(input string name, input [31:0] e, input [31:0] g);
        samples_checked = samples_checked + 1;
        if (g !== e) begin
            fail_count = fail_count + 1;
            $display("[FAIL] %0s expected %h seen %h", name, e, g);
        end
    endtask
    task test_done;
        $display("samples_checked %0d fail_count %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // Request is held from setup until pready is sampled high
    task apb(input w, input [11:0] a, input [31:0] wd, input [3:0] sb);
        integer n;
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata, pstrb} <= {1'b1, w, a, wd, sb};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 50) begin
            @(posedge pclk);
            n = n + 1;
        end
        got = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
        if (n >= 50) fail_count = fail_count + 1;
    endtask
    task conv(input [17:0] r);
        @(posedge pclk);
        {conv_valid, conv_result} <= {1'b1, r};
        @(posedge pclk);
        {conv_valid, conv_result} <= {1'b0, rnd() & 32'h0003FFFF};
        @(posedge pclk);
    endtask
    always @(posedge pclk) begin
        cycles = cycles + 1;
        if (cycles == 5000) begin
            fail_count = fail_count + 1;
            test_done;
        end
    end
    // =====================================================================
    // Main sequence
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 12'h024, 32'h0, 4'h0);
        chk("upper reset", 32'h0000FFFF, got);
        chk("read no err", 32'h0, {31'h0, err});
        apb(1'b0, 12'h028, 32'h0, 4'h0);
        chk("lower reset", 32'h00000000, got);
        e_up = 32'h0000FFFF;
        e_lo = 32'h00000000;
        // Single lanes first, then random strobes, on both registers
        for (i = 0; i < 24; i = i + 1) begin
            d = rnd() & 32'hFCFFFFFF;
            s = (i < 8) ? (4'h1 << (i / 2)) : rnd();
            apb(1'b1, i[0] ? 12'h028 : 12'h024, d, s);
            if (i[0]) e_lo = merge(e_lo, d, s, 32'h0000FFFF);
            else e_up = merge(e_up, d, s, 32'hFC00FFFF);
            apb(1'b0, i[0] ? 12'h028 : 12'h024, 32'h0, 4'h0);
            chk("threshold", i[0] ? e_lo : e_up, got);
        end
        apb(1'b0, 12'h030, 32'h0, 4'h0);
        chk("unmapped err", 32'h1, {31'h0, err});
        apb(1'b1, 12'h020, rnd(), 4'hF);
        chk("status write err", 32'h1, {31'h0, err});
        apb(1'b1, 12'h024, 32'h10008000, 4'hF);
        apb(1'b1, 12'h028, 32'h00001000, 4'hF);
        for (i = 5; i >= 0; i = i - 1) begin
            x = tbl[22 * i +: 22];
            conv(x[21:4]);
            chk("alarm pins", stat(x[3:0]) & 32'h00000C01, {20'h0, alarm_under_r, alarm_over_r,
                9'h0, summary_alarm_bit_r});
            apb(1'b0, 12'h020, 32'h0, 4'h0);
            chk("status", stat(x[3:0]), got);
        end
        apb(1'b0, 12'h02C, 32'h0, 4'h0);
        chk("last result", {14'h0, tbl[21:4]}, got);
        apb(1'b1, 12'h02C, 32'h0, 4'hF);
        chk("result write err", 32'h1, {31'h0, err});
        test_done;
    end
endmodule // iatr_regs_tb
